// ---- dtap_pkg.sv ----
// constants, field layouts and types for the debug test port scan registers
// Function
// - id bits 31:28 version from strap pins
// - id bits 27:12 part number from straps
// - id bits 11:1 maker identity from straps
// - id bit 0 always reads one
// - 32-bit read-only implementation register, impl instruction
// - impl bit 24 shows probe interrupt support
// - impl bits 23:21 give address-space id size
// - control register 32 bits, control instruction
// - control written and read only by shifting
// - only the test port reaches control register
// - update blocked while reset-occurred stays one
// - cpu resets load control defaults, tap reset not
// - defaults still load when test clock resumes
// - first five test clocks may re-reset control
// - access flags sit at bits 22 to 18
// - test-logic-reset and capture-ir load 00001
// - identity instruction selects identification register
// - capture/shift on rising edge, output on falling
// - reset-occurred set and held during reset
package dtap_pkg;

   localparam logic [4:0] IR_IDENT = 5'h01;
   localparam logic [4:0] IR_IMPL = 5'h03;
   localparam logic [4:0] IR_CTRL = 5'h0A;
   localparam logic [4:0] IR_BYPASS = 5'h1F;
   localparam logic [4:0] IR_CAPTURE_PAT = 5'h01;

   localparam int ID_VER_LSB = 28;
   localparam int ID_PART_LSB = 12;
   localparam int ID_MAKER_LSB = 1;
   localparam logic ID_RSVD_BIT = 1'b1;

   localparam int IMPL_VER_LSB = 29;
   localparam int IMPL_IRQ_BIT = 24;
   localparam int IMPL_ASID_LSB = 21;
   localparam int IMPL_ISA_BIT = 16;
   localparam int IMPL_NO_DMA_BIT = 14;
   localparam logic [2:0] IMPL_VERSION = 3'h5;
   localparam logic [2:0] IMPL_ASID_SIZE = 3'h2;
   localparam logic IMPL_COMPRESSED = 1'b0;
   localparam logic IMPL_NO_DMA = 1'b1;

   localparam int CTL_ROCC = 31;
   localparam int CTL_PSZ_LSB = 29;
   localparam int CTL_DOZE = 22;
   localparam int CTL_HALT = 21;
   localparam int CTL_PERIPH_RESET = 20;
   localparam int CTL_RNW = 19;
   localparam int CTL_PEND = 18;
   localparam int CTL_PROC_RESET = 16;
   localparam int CTL_PROBE_EN = 15;
   localparam int CTL_TRAP = 14;
   localparam int CTL_BRK = 12;
   localparam int CTL_DEBUG_MODE = 3;
   localparam logic [31:0] CTL_WR_MASK = 32'h0011_D000;
   localparam logic [31:0] CTL_RESET = 32'h8000_0000;

   localparam int CPU_RST_TCK_CYCLES = 5;

   typedef enum logic [3:0] {
      ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
      ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7,
      ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SH_IR = 4'hB,
      ST_EX1_IR = 4'hC, ST_PA_IR = 4'hD, ST_EX2_IR = 4'hE, ST_UPD_IR = 4'hF
   } dtap_state_t;

   typedef struct packed {
      logic [1:0] size;
      logic doze;
      logic halt;
      logic read_not_write;
      logic pending;
      logic debug_mode;
   } dtap_status_t;

   typedef struct packed {
      logic peripheral_reset;
      logic processor_reset;
      logic probe_enabled;
      logic probe_trap_vector;
      logic debug_break_request;
   } dtap_ctl_t;

endpackage

// ---- dtap_sync.sv ----
// two-flop level synchroniser, one flop pair per bit
`timescale 1ns/1ps
`default_nettype none
module dtap_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;

   // first stage feeds only the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= '0;
         q <= '0;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// ---- dtap_regs.sv ----
// debug test port: tap controller, identity, implementation and control registers
`timescale 1ns/1ps
`default_nettype none
module dtap_regs (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cpu_hard_rst,
   input wire logic cpu_soft_rst,
   input wire logic [3:0] version_strap_in,
   input wire logic [15:0] part_strap_in,
   input wire logic [10:0] maker_strap_in,
   input wire logic probe_irq_support_in,
   input wire dtap_pkg::dtap_status_t core_status,
   output dtap_pkg::dtap_ctl_t ctl_out,
   input wire logic tck,
   input wire logic tap_rst,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe
);
   import dtap_pkg::*;

   // ---------------- mclk side: cpu reset request ----------------
   logic req_ff;
   logic nxt_req;
   logic ack_m;
   dtap_ctl_t ctl_m;
   wire cpu_rst = cpu_hard_rst | cpu_soft_rst;

   // request is sticky so a reset with tck stopped is not lost
   // hold until acknowledged
   assign nxt_req = cpu_rst ? 1'b1 : (ack_m ? 1'b0 : req_ff);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         req_ff <= 1'b1;
      end else begin
         req_ff <= nxt_req;
      end
   end

   logic [5:0] back_q;
   logic ack_ff;
   logic [31:0] ctl_ff;

   dtap_sync #(.W(6)) u_sync_m (
      .clk(mclk),
      .rst(rst),
      .d({ack_ff, ctl_ff[CTL_PERIPH_RESET], ctl_ff[CTL_PROC_RESET], ctl_ff[CTL_PROBE_EN],
          ctl_ff[CTL_TRAP], ctl_ff[CTL_BRK]}),
      .q(back_q)
   );

   assign ack_m = back_q[5];
   assign ctl_m = back_q[4:0];
   assign ctl_out = ctl_m;

   // ---------------- tck side: inputs crossing in ----------------
   logic [39:0] in_q;
   logic req_t;
   logic [3:0] ver_t;
   logic [15:0] part_t;
   logic [10:0] maker_t;
   logic irq_sup_t;
   dtap_status_t stat_t;

   // straps and status come from the core clock domain
   dtap_sync #(.W(40)) u_sync_t (
      .clk(tck),
      .rst(tap_rst),
      .d({req_ff, version_strap_in, part_strap_in, maker_strap_in,
          probe_irq_support_in, core_status}),
      .q(in_q)
   );

   assign req_t = in_q[39];
   assign ver_t = in_q[38:35];
   assign part_t = in_q[34:19];
   assign maker_t = in_q[18:8];
   assign irq_sup_t = in_q[7];
   assign stat_t = in_q[6:0];

   always_ff @(posedge tck or posedge tap_rst) begin
      if (tap_rst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req_t;
      end
   end

   // ---------------- tap state machine ----------------
   dtap_state_t state_ff;
   dtap_state_t nxt_state;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_TLR: nxt_state = tms ? ST_TLR : ST_RTI;
         ST_RTI: nxt_state = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: nxt_state = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: nxt_state = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: nxt_state = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: nxt_state = tms ? ST_UPD_DR : ST_PA_DR;
         ST_PA_DR: nxt_state = tms ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: nxt_state = tms ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: nxt_state = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: nxt_state = tms ? ST_TLR : ST_CAP_IR;
         ST_CAP_IR: nxt_state = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: nxt_state = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: nxt_state = tms ? ST_UPD_IR : ST_PA_IR;
         ST_PA_IR: nxt_state = tms ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: nxt_state = tms ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: nxt_state = tms ? ST_SEL_DR : ST_RTI;
         default: nxt_state = ST_TLR;
      endcase
   end

   always_ff @(posedge tck or posedge tap_rst) begin
      if (tap_rst) begin
         state_ff <= ST_TLR;
      end else begin
         state_ff <= nxt_state;
      end
   end

   wire in_tlr = (state_ff == ST_TLR);
   wire cap_ir = (state_ff == ST_CAP_IR);
   wire sh_ir = (state_ff == ST_SH_IR);
   wire upd_ir = (state_ff == ST_UPD_IR);
   wire cap_dr = (state_ff == ST_CAP_DR);
   wire sh_dr = (state_ff == ST_SH_DR);
   wire upd_dr = (state_ff == ST_UPD_DR);

   // ---------------- instruction register ----------------
   logic [4:0] ir_sh_ff;
   logic [4:0] ir_ff;
   logic [4:0] nxt_ir_sh;
   logic [4:0] nxt_ir;

   assign nxt_ir_sh = (in_tlr | cap_ir) ? IR_CAPTURE_PAT :
                      sh_ir ? {tdi, ir_sh_ff[4:1]} : ir_sh_ff;
   assign nxt_ir = in_tlr ? IR_IDENT : (upd_ir ? ir_sh_ff : ir_ff);

   always_ff @(posedge tck or posedge tap_rst) begin
      if (tap_rst) begin
         ir_sh_ff <= IR_CAPTURE_PAT;
         ir_ff <= IR_IDENT;
      end else begin
         ir_sh_ff <= nxt_ir_sh;
         ir_ff <= nxt_ir;
      end
   end

   wire sel_ident = (ir_ff == IR_IDENT);
   wire sel_impl = (ir_ff == IR_IMPL);
   wire sel_ctrl = (ir_ff == IR_CTRL);
   wire sel_bypass = ~(sel_ident | sel_impl | sel_ctrl);

   // ---------------- read-only words ----------------
   logic [31:0] id_word;
   logic [31:0] impl_word;
   logic [31:0] ctl_view;

   assign id_word[31:ID_VER_LSB] = ver_t;
   assign id_word[ID_VER_LSB-1:ID_PART_LSB] = part_t;
   assign id_word[ID_PART_LSB-1:ID_MAKER_LSB] = maker_t;
   assign id_word[0] = ID_RSVD_BIT;

   assign impl_word[31:IMPL_VER_LSB] = IMPL_VERSION;
   assign impl_word[IMPL_VER_LSB-1:IMPL_IRQ_BIT+1] = '0;
   assign impl_word[IMPL_IRQ_BIT] = irq_sup_t;
   assign impl_word[IMPL_IRQ_BIT-1:IMPL_ASID_LSB] = IMPL_ASID_SIZE;
   assign impl_word[IMPL_ASID_LSB-1:IMPL_ISA_BIT+1] = '0;
   assign impl_word[IMPL_ISA_BIT] = IMPL_COMPRESSED;
   assign impl_word[IMPL_ISA_BIT-1] = 1'b0;
   assign impl_word[IMPL_NO_DMA_BIT] = IMPL_NO_DMA;
   assign impl_word[IMPL_NO_DMA_BIT-1:0] = '0;

   // status bits merged over the stored writable bits
   // access flags 22:18
   always_comb begin
      ctl_view = ctl_ff & (CTL_WR_MASK | CTL_RESET);
      ctl_view[CTL_PSZ_LSB+1:CTL_PSZ_LSB] = stat_t.size;
      ctl_view[CTL_DOZE] = stat_t.doze;
      ctl_view[CTL_HALT] = stat_t.halt;
      ctl_view[CTL_RNW] = stat_t.read_not_write;
      ctl_view[CTL_PEND] = stat_t.pending;
      ctl_view[CTL_DEBUG_MODE] = stat_t.debug_mode;
   end

   // ---------------- data shift register ----------------
   logic [31:0] dr_ff;
   logic [31:0] nxt_dr;
   logic [31:0] cap_word;

   assign cap_word = sel_ident ? id_word :
                     sel_impl ? impl_word :
                     sel_ctrl ? ctl_view : 32'h0000_0000;

   // capture and shift on rising tck
   always_comb begin
      nxt_dr = dr_ff;
      if (cap_dr) begin
         nxt_dr = cap_word;
      end else if (sh_dr) begin
         if (sel_bypass) begin
            nxt_dr = {31'h0000_0000, tdi};
         end else begin
            nxt_dr = {tdi, dr_ff[31:1]};
         end
      end
   end

   always_ff @(posedge tck or posedge tap_rst) begin
      if (tap_rst) begin
         dr_ff <= 32'h0000_0000;
      end else begin
         dr_ff <= nxt_dr;
      end
   end

   // ---------------- control register ----------------
   logic [31:0] nxt_ctl;
   wire upd_ok = ~ctl_ff[CTL_ROCC] | ~dr_ff[CTL_ROCC];

   // cpu reset wins over a concurrent update; tap reset never touches it
   always_comb begin
      nxt_ctl = ctl_ff;
      if (req_t) begin
         nxt_ctl = CTL_RESET;
      end else if (upd_dr & sel_ctrl & upd_ok) begin
         nxt_ctl = (dr_ff & CTL_WR_MASK) |
                   {ctl_ff[CTL_ROCC] & dr_ff[CTL_ROCC], 31'h0000_0000};
      end
   end

   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         ctl_ff <= CTL_RESET;
      end else begin
         ctl_ff <= nxt_ctl;
      end
   end

   // ---------------- test data out ----------------
   // output changes on falling edge
   always_ff @(negedge tck or posedge tap_rst) begin
      if (tap_rst) begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end else begin
         tdo <= sh_ir ? ir_sh_ff[0] : dr_ff[0];
         tdo_oe <= sh_ir | sh_dr;
      end
   end

   // ---------------- checks ----------------
   AST_ID_WORD: assert property (@(posedge tck) disable iff (tap_rst)
      (cap_dr & sel_ident) |=> (dr_ff[31:ID_VER_LSB] == $past(ver_t)))
      else $error("identity version field wrong after capture");

   AST_ID_PART: assert property (@(posedge tck) disable iff (tap_rst)
      (cap_dr & sel_ident) |=> (dr_ff[27:12] == $past(part_t)))
      else $error("identity part field wrong after capture");

   AST_ID_MAKER: assert property (@(posedge tck) disable iff (tap_rst)
      (cap_dr & sel_ident) |=> (dr_ff[11:1] == $past(maker_t)))
      else $error("identity maker field wrong after capture");

   AST_ID_LSB: assert property (@(posedge tck) disable iff (tap_rst)
      (cap_dr & sel_ident) |=> dr_ff[0])
      else $error("identity bit zero not one");

   AST_IMPL_FIXED: assert property (@(posedge tck) disable iff (tap_rst)
      (cap_dr & sel_impl) |=> (dr_ff[31:29] == 3'h5 && dr_ff[14] && dr_ff[13:0] == 14'h0))
      else $error("implementation fixed fields wrong");

   AST_IMPL_IRQ: assert property (@(posedge tck) disable iff (tap_rst)
      (cap_dr & sel_impl) |=> (dr_ff[24] == $past(irq_sup_t)))
      else $error("implementation irq support bit wrong");

   AST_IMPL_ASID: assert property (@(posedge tck) disable iff (tap_rst)
      (cap_dr & sel_impl) |=> (dr_ff[23:21] == 3'h2 && dr_ff[20:17] == 4'h0))
      else $error("implementation asid size wrong");

   AST_IMPL_ISA: assert property (@(posedge tck) disable iff (tap_rst)
      (cap_dr & sel_impl) |=> !dr_ff[16])
      else $error("compressed isa bit not zero");

   AST_CTRL_SHIFT: assert property (@(posedge tck) disable iff (tap_rst)
      (sh_dr & sel_ctrl) |=> (dr_ff[31] == $past(tdi) && dr_ff[30:0] == $past(dr_ff[31:1])))
      else $error("control shift path broken");

   AST_ROCC_GUARD: assert property (@(posedge tck) disable iff (tap_rst || rst)
      (upd_dr & sel_ctrl & ctl_ff[31] & dr_ff[31] & !req_t) |=> $stable(ctl_ff))
      else $error("control updated while reset flag set");

   AST_CPU_RST: assert property (@(posedge tck) disable iff (tap_rst || rst)
      req_t |=> (ctl_ff == 32'h8000_0000))
      else $error("control not at reset values during cpu reset");

   AST_IR_CAPTURE: assert property (@(posedge tck) disable iff (tap_rst)
      (in_tlr | cap_ir) |=> (ir_sh_ff == 5'h01))
      else $error("instruction shift not preset");

   AST_TLR_SEL: assert property (@(posedge tck) disable iff (tap_rst)
      in_tlr |=> sel_ident)
      else $error("identity not selected after test-logic-reset");

   AST_REQ_HOLD: assert property (@(posedge mclk) disable iff (rst)
      (cpu_rst || (req_ff && !ack_m)) |=> req_ff)
      else $error("cpu reset request dropped before acknowledge");

   AST_TDO_OE: assert property (@(posedge tck) disable iff (tap_rst)
      tdo_oe == (sh_ir | sh_dr))
      else $error("data out enable not matching shift states");

   AST_TDO_BIT: assert property (@(posedge tck) disable iff (tap_rst)
      sh_dr |-> (tdo == dr_ff[0]))
      else $error("data out not showing shift register bit");

   AST_CTRL_WRITE: assert property (@(posedge tck) disable iff (tap_rst || rst)
      (upd_dr & sel_ctrl & !dr_ff[31] & !req_t) |=> (ctl_ff == ($past(dr_ff) & CTL_WR_MASK)))
      else $error("control write did not land");

endmodule
`default_nettype wire

// ---- dtap_probe.sv ----
// probe model driving the test port pins
`timescale 1ns/1ps
`default_nettype none
module dtap_probe (
   output logic tck,
   output logic tap_rst,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   // tms and tdi rest at their pull-up level
   initial begin
      tck = 1'b0;
      tap_rst = 1'b1;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // one test clock; tck rests low between frames
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #15 tck = 1'b1;
      q = tdo;
      #15 tck = 1'b0;
   endtask
   // pulse test reset, then step into run-test-idle
   task automatic trst();
      logic q;
      tap_rst = 1'b1;
      #20 tap_rst = 1'b0;
      #7 step(1'b0, 1'b1, q);
   endtask
   // idle clocks, early post-reset writes not relied on
   task automatic idle(input int n);
      logic q;
      for (int i = 0; i < n; i++) step(1'b0, 1'b1, q);
   endtask
   // writes by shifting, flag cleared via bit 31
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic q;
      dout = '0;
      step(1'b1, 1'b1, q);
      if (ir) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      tms = 1'b1;
      tdi = 1'b1;
   endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the debug test port registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dtap_pkg::*;
   typedef struct packed {
      logic [3:0] ver;
      logic [15:0] part;
      logic [10:0] maker;
      logic irq;
      logic [31:0] id;
      logic [31:0] impl;
   } dtap_row_t;
   localparam logic [31:0] STS = 32'h4048_0008;
   localparam logic [31:0] WR1 = 32'h0011_D000;
   localparam logic [31:0] RST_RD = 32'hC048_0008;
   localparam logic [31:0] SET_RD = 32'h4059_D008;
   logic mclk, rst, cpu_hard_rst, cpu_soft_rst;
   logic [3:0] version_strap_in;
   logic [15:0] part_strap_in;
   logic [10:0] maker_strap_in;
   logic probe_irq_support_in;
   dtap_status_t core_status;
   dtap_ctl_t ctl_out;
   logic tck, tap_rst, tms, tdi, tdo, tdo_oe;
   int mismatches = 0;
   int checked = 0;
   dtap_row_t rows [3] = '{
      '{4'h3, 16'hA5C3, 11'h2B5, 1'b1, 32'h3A5C_356B, 32'hA140_4000},
      '{4'hF, 16'hFFFF, 11'h7FF, 1'b0, 32'hFFFF_FFFF, 32'hA040_4000},
      '{4'h0, 16'h0000, 11'h000, 1'b1, 32'h0000_0001, 32'hA140_4000}
   };
   dtap_regs dtap_regs_i (.mclk(mclk), .rst(rst), .cpu_hard_rst(cpu_hard_rst),
      .cpu_soft_rst(cpu_soft_rst), .version_strap_in(version_strap_in),
      .part_strap_in(part_strap_in), .maker_strap_in(maker_strap_in),
      .probe_irq_support_in(probe_irq_support_in), .core_status(core_status),
      .ctl_out(ctl_out), .tck(tck), .tap_rst(tap_rst), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe));
   dtap_probe dtap_probe_i (.tck(tck), .tap_rst(tap_rst), .tms(tms), .tdi(tdi),
      .tdo(tdo));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic load_ir(input logic [4:0] code);
      logic [31:0] cap;
      dtap_probe_i.scan(1'b1, 5, {27'h0, code}, cap);
      check(cap, {27'h0, IR_CAPTURE_PAT});
   endtask
   // full data scan, captured word against expectation
   task automatic dr(input logic [31:0] din, input logic [31:0] exp);
      logic [31:0] cap;
      dtap_probe_i.scan(1'b0, 32, din, cap);
      check(cap, exp);
   endtask
   // bounded wait, ctl_out crosses two clock domains
   task automatic wait_ctl(input dtap_ctl_t exp);
      for (int i = 0; i < 100 && ctl_out !== exp; i++) @(posedge mclk);
      check({27'h0, ctl_out}, {27'h0, exp});
   endtask
   initial begin
      rst = 1'b1;
      cpu_hard_rst = 1'b0;
      cpu_soft_rst = 1'b0;
      version_strap_in = 4'h0;
      part_strap_in = 16'h0000;
      maker_strap_in = 11'h000;
      probe_irq_support_in = 1'b0;
      core_status = 7'h55;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      dtap_probe_i.trst();
      dr(32'h0, 32'h0000_0001);
      foreach (rows[r]) begin
         @(posedge mclk);
         version_strap_in <= rows[r].ver;
         part_strap_in <= rows[r].part;
         maker_strap_in <= rows[r].maker;
         probe_irq_support_in <= rows[r].irq;
         repeat (4) @(posedge mclk);
         load_ir(IR_IDENT);
         dr(32'hFFFF_FFFE, rows[r].id);
         dr(32'h0, rows[r].id);
         load_ir(IR_IMPL);
         dr(32'hFFFF_FFFF, rows[r].impl);
         dr(32'h0, rows[r].impl);
      end
      load_ir(IR_BYPASS);
      dr(32'hA5A5_A5A5, 32'h4B4B_4B4A);
      load_ir(IR_CTRL);
      dr(32'h8011_D000, RST_RD);
      dr(WR1, RST_RD);
      wait_ctl(5'h1F);
      dr(32'h0, SET_RD);
      wait_ctl(5'h00);
      dr(WR1, STS);
      wait_ctl(5'h1F);
      dtap_probe_i.trst();
      load_ir(IR_CTRL);
      dr(WR1, SET_RD);
      // test clock stays stopped while the cpu reset is applied
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk);
         cpu_hard_rst <= (k == 0);
         cpu_soft_rst <= (k == 1);
         repeat (3) @(posedge mclk);
         cpu_hard_rst <= 1'b0;
         cpu_soft_rst <= 1'b0;
         repeat (20) @(posedge mclk);
         dtap_probe_i.idle(8);
         wait_ctl(5'h00);
         dr(WR1, RST_RD);
         dr(WR1, SET_RD);
         wait_ctl(5'h1F);
      end
      check({31'h0, tdo_oe}, 32'h0);
      close_out();
   end
   // watchdog, well beyond the roughly 29 us that the tests take
   initial begin
      #300000;
      mismatches++;
      close_out();
   end
endmodule
`default_nettype wire
